// File: pkg/stb_diag_pkg.sv
`default_nettype none
package stb_diag_pkg;
	// Register offsets in the user sub map
	localparam logic [7:0] STB_SENSE_A_CTRL_OFS = 8'h5D;
	localparam logic [7:0] STB_SENSE_B_CTRL_OFS = 8'h5E;
	// Status register holding latched events, read clears
	localparam logic [7:0] STB_STATUS_OFS = 8'h5F;
	// Field positions
	localparam int COMP_OFF_BIT = 6;
	localparam int THRESH_LSB = 2;
	localparam int THRESH_MSB = 4;
	// Reset values
	localparam logic COMP_OFF_RST = 1'b1;
	localparam logic [2:0] THRESH_RST = 3'h3;
	// Sub map select value for the user sub map
	localparam logic [1:0] SUBMAP_USER = 2'h0;
	// Threshold in mV: 75 + 150 * code
	localparam int THRESH_BASE_MV = 75;
	localparam int THRESH_STEP_MV = 150;
endpackage
`default_nettype wire

// File: logic/battery_short_diagnostics.sv
`timescale 1ns/10ps
`default_nettype none
module battery_short_diagnostics
	import stb_diag_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_reset,
	input wire logic i_clk_en,
	// Register port from the serial slave, sub map already decoded
	input wire logic [1:0] i_submap_select,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	output logic o_reg_hit,
	// Analog comparator outputs (asynchronous)
	input wire logic i_sense_input_a_cmp,
	input wire logic i_sense_input_b_cmp,
	// To the analog slicers, plus the interrupt request pin
	output logic o_sense_a_comparator_off,
	output logic [2:0] o_sense_a_threshold,
	output logic o_sense_b_comparator_off,
	output logic [2:0] o_sense_b_threshold,
	output logic o_interrupt_request_pin
);

	//--------------------------------------------------
	// State
	//--------------------------------------------------
	typedef struct packed {
		logic [1:0] off;
		logic [1:0][2:0] thresh;
		logic [1:0] sync1;
		logic [1:0] sync2;
		logic [1:0] evt;
		logic [7:0] rdata;
		logic irq; // Registered copy of any-event for the pin
	} state_t;

	// Current and next state, plus decode helpers
	state_t st_r;
	state_t st_nxt;
	logic user_map;
	logic [1:0] cmp_in;
	logic [1:0] sel_wr;
	logic [1:0] rd_clr;

	// Access decode; a foreign sub map sees none of these registers
	assign user_map = (i_submap_select == SUBMAP_USER);
	assign cmp_in = {i_sense_input_b_cmp, i_sense_input_a_cmp};
	assign sel_wr[0] = user_map && i_reg_wr && (i_reg_addr == STB_SENSE_A_CTRL_OFS);
	assign sel_wr[1] = user_map && i_reg_wr && (i_reg_addr == STB_SENSE_B_CTRL_OFS);

	//--------------------------------------------------
	// Next state
	//--------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		rd_clr = 2'h0;
		st_nxt.sync1 = cmp_in;
		st_nxt.sync2 = st_r.sync1;
		// Status read clears what was shown; a new event in the same cycle still sets
		if (user_map && i_reg_rd && i_reg_addr == STB_STATUS_OFS) begin
			rd_clr = st_r.evt;
		end
		for (int i = 0; i < 2; i++) begin
			if (sel_wr[i]) begin
				st_nxt.off[i] = i_reg_wdata[COMP_OFF_BIT];
				st_nxt.thresh[i] = i_reg_wdata[THRESH_MSB:THRESH_LSB];
			end
			// Powered-down slicer output is ignored, so detection stays off until enabled
			st_nxt.evt[i] = (st_r.evt[i] & ~rd_clr[i]) | (st_r.sync2[i] & ~st_r.off[i]);
		end
		// Interrupt pin from its own flop so it cannot glitch while events change
		st_nxt.irq = |st_nxt.evt;
		// Read data captured for the serial slave
		st_nxt.rdata = 8'h00;
		if (user_map) begin
			case (i_reg_addr)
				STB_SENSE_A_CTRL_OFS: st_nxt.rdata = {1'b0, st_r.off[0], 1'b0, st_r.thresh[0], 2'h0};
				STB_SENSE_B_CTRL_OFS: st_nxt.rdata = {1'b0, st_r.off[1], 1'b0, st_r.thresh[1], 2'h0};
				STB_STATUS_OFS: st_nxt.rdata = {6'h00, st_r.evt};
				default: st_nxt.rdata = 8'h00;
			endcase
		end
	end

	//--------------------------------------------------
	// Registers
	//--------------------------------------------------
	// Reset needs no clock enable, so a frozen core still comes up powered down
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			st_r.off <= {COMP_OFF_RST, COMP_OFF_RST};
			st_r.thresh <= {THRESH_RST, THRESH_RST};
			st_r.sync1 <= 2'h0;
			st_r.sync2 <= 2'h0;
			st_r.evt <= 2'h0;
			st_r.rdata <= 8'h00;
			st_r.irq <= 1'b0;
		end else if (i_clk_en) begin
			st_r <= st_nxt;
		end
	end

	// Outputs
	assign o_reg_rdata = st_r.rdata;
	assign o_reg_hit = user_map && (i_reg_addr == STB_SENSE_A_CTRL_OFS || i_reg_addr == STB_SENSE_B_CTRL_OFS
		|| i_reg_addr == STB_STATUS_OFS);
	assign o_sense_a_comparator_off = st_r.off[0];
	assign o_sense_a_threshold = st_r.thresh[0];
	assign o_sense_b_comparator_off = st_r.off[1];
	assign o_sense_b_threshold = st_r.thresh[1];
	assign o_interrupt_request_pin = st_r.irq;

	//--------------------------------------------------
	// Checks
	//--------------------------------------------------
	// All checks share the core clock; all but chk_reset_state drop out during reset
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_reset);

	sequence s_trip_a;
		i_clk_en && st_r.sync2[0] && !st_r.off[0];
	endsequence

	chk_trip_sets_irq: assert property (s_trip_a |=> o_interrupt_request_pin)
		else $error("interrupt not raised after trip");
	chk_status_reads_evt: assert property (i_clk_en && user_map && i_reg_addr == STB_STATUS_OFS
		|=> o_reg_rdata == {6'h00, $past(st_r.evt)})
		else $error("status readback wrong");
	chk_off_blocks_evt: assert property (i_clk_en && st_r.off == 2'h3 && !rd_clr[0] && !st_r.evt[0]
		|=> !st_r.evt[0])
		else $error("event while comparator off");
	chk_wr_a_off: assert property (i_clk_en && sel_wr[0] |=> o_sense_a_comparator_off == $past(i_reg_wdata[6]))
		else $error("comparator A off bit not written");
	chk_wr_a_thr: assert property (i_clk_en && sel_wr[0] |=> o_sense_a_threshold == $past(i_reg_wdata[4:2]))
		else $error("threshold A not written");
	chk_wr_b_off: assert property (i_clk_en && sel_wr[1] |=> o_sense_b_comparator_off == $past(i_reg_wdata[6]))
		else $error("comparator B off bit not written");
	chk_wr_b_thr: assert property (i_clk_en && sel_wr[1] |=> o_sense_b_threshold == $past(i_reg_wdata[4:2]))
		else $error("threshold B not written");
	chk_evt_held: assert property (st_r.evt[1] && !rd_clr[1] |=> st_r.evt[1])
		else $error("event lost before clear");
	chk_submap_gate: assert property (!user_map && i_clk_en |=> $stable(st_r.off) && $stable(st_r.thresh))
		else $error("write outside user sub map took effect");

	//--------------------------------------------------
	// Further checks: channel B, trip flags, clearing, readback, decode, freezing and reset
	//--------------------------------------------------
	// Trip on channel B, the mirror of channel A
	sequence s_trip_b;
		i_clk_en && st_r.sync2[1] && !st_r.off[1];
	endsequence

	// Enabled status read in the user sub map
	sequence s_status_read;
		i_clk_en && user_map && i_reg_rd && i_reg_addr == STB_STATUS_OFS;
	endsequence

	// Address of one of the two control registers, read strobe or not
	sequence s_ctrl_a_addr;
		i_clk_en && user_map && i_reg_addr == STB_SENSE_A_CTRL_OFS;
	endsequence

	sequence s_ctrl_b_addr;
		i_clk_en && user_map && i_reg_addr == STB_SENSE_B_CTRL_OFS;
	endsequence

	// Event and interrupt follow a trip one edge later
	chk_trip_b_irq: assert property (s_trip_b |=> st_r.evt[1] && o_interrupt_request_pin)
		else $error("interrupt not raised after trip on B");
	chk_trip_a_flag: assert property (s_trip_a |=> st_r.evt[0])
		else $error("event A not flagged after trip");
	chk_evt_held_a: assert property (st_r.evt[0] && !rd_clr[0] |=> st_r.evt[0])
		else $error("event A lost before clear");
	// A read clears what it showed; only a trip in the same cycle may set it again
	chk_read_clears: assert property (s_status_read |=> st_r.evt == $past(st_r.sync2 & ~st_r.off))
		else $error("status read did not clear events");
	// Two flip-flops stand between the comparator pins and the event logic
	chk_sync_depth: assert property (i_clk_en |=> st_r.sync2 == $past(st_r.sync1))
		else $error("synchroniser skipped a stage");
	chk_rd_ctrl_a: assert property (s_ctrl_a_addr
		|=> o_reg_rdata[COMP_OFF_BIT] == $past(st_r.off[0])
		&& o_reg_rdata[THRESH_MSB:THRESH_LSB] == $past(st_r.thresh[0]))
		else $error("control A readback wrong");
	chk_rd_ctrl_b: assert property (s_ctrl_b_addr
		|=> o_reg_rdata[COMP_OFF_BIT] == $past(st_r.off[1])
		&& o_reg_rdata[THRESH_MSB:THRESH_LSB] == $past(st_r.thresh[1]))
		else $error("control B readback wrong");
	// Unmapped or foreign accesses return zero so software never sees stale data
	chk_unmapped_zero: assert property (i_clk_en && !o_reg_hit |=> o_reg_rdata == 8'h00)
		else $error("unmapped read returned data");
	// Decode sanity and the channel B power-down gate
	chk_status_hit: assert property (user_map && i_reg_addr == STB_STATUS_OFS |-> o_reg_hit)
		else $error("status register not mapped");
	chk_foreign_no_hit: assert property (!user_map |-> !o_reg_hit)
		else $error("hit outside user sub map");
	chk_off_blocks_b: assert property (i_clk_en && st_r.off[1] && !st_r.evt[1] |=> !st_r.evt[1])
		else $error("event B while comparator off");
	// Clock enable low freezes every bit of state, synchronisers included
	chk_freeze_en: assert property (!i_clk_en |=> $stable(st_r))
		else $error("state moved while clock enable low");
	// Reset is honoured without clock enable and leaves both slicers powered down
	chk_reset_state: assert property (@(posedge i_core_clk) disable iff (1'b0) i_reset
		|=> o_sense_a_comparator_off && o_sense_b_comparator_off && o_sense_a_threshold == THRESH_RST
		&& o_sense_b_threshold == THRESH_RST && !o_interrupt_request_pin)
		else $error("reset values wrong");

endmodule
`default_nettype wire

// File: sim/sense_divider.sv
`timescale 1ns/10ps
`default_nettype none
// Connector divider feeding one slicer
module sense_divider
	import stb_diag_pkg::*;
#(parameter int DIV_TOP = 3, parameter int DIV_BOT = 1)
(
	input var int i_conn_mv,
	input wire logic i_off,
	input wire logic [2:0] i_thresh,
	output logic o_cmp
);
	// Pin sees the connector over the divider ratio, compared to the code level.
	// A powered-down slicer has no valid level and trips on any positive pin voltage,
	// so only the core's own gate keeps a disabled input quiet
	assign o_cmp = i_conn_mv * DIV_BOT / (DIV_TOP + DIV_BOT)
		> (i_off ? 0 : THRESH_BASE_MV + THRESH_STEP_MV * int'(i_thresh));
endmodule
`default_nettype wire

// File: sim/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin miscompares++; $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module testbench
	import stb_diag_pkg::*;
;
	localparam int RATIO = 4;
	logic clk, rst, wr_s, rd_s, hit, irq, en;
	logic [1:0] sub;
	wire logic [1:0] off, cmp;
	logic [7:0] addr, wdata, rdata;
	logic [2:0] thr [2];
	int vin [2], m_off [2], m_thr [2], m_evt, miscompares, total_checks, cycles, i, k, lim;
	integer seed;
	battery_short_diagnostics battery_short_diagnostics_inst (.i_core_clk(clk), .i_reset(rst), .i_clk_en(en),
		.i_submap_select(sub), .i_reg_wr(wr_s), .i_reg_rd(rd_s), .i_reg_addr(addr), .i_reg_wdata(wdata),
		.o_reg_rdata(rdata), .o_reg_hit(hit), .i_sense_input_a_cmp(cmp[0]), .i_sense_input_b_cmp(cmp[1]),
		.o_sense_a_comparator_off(off[0]), .o_sense_a_threshold(thr[0]), .o_sense_b_comparator_off(off[1]),
		.o_sense_b_threshold(thr[1]), .o_interrupt_request_pin(irq));
	sense_divider #(.DIV_TOP(RATIO - 1)) sense_divider_inst (.i_conn_mv(vin[0]), .i_off(off[0]), .i_thresh(thr[0]), .o_cmp(cmp[0]));
	sense_divider #(.DIV_TOP(RATIO - 1)) sense_divider_b_inst (.i_conn_mv(vin[1]), .i_off(off[1]), .i_thresh(thr[1]), .o_cmp(cmp[1]));
	task automatic cyc(); @(posedge clk); #1; endtask
	task automatic wr(input logic [7:0] a, d); wr_s = 1; addr = a; wdata = d; cyc(); wr_s = 0; endtask
	// Read data lands one edge after the address; hit is checked while the address stands
	task automatic rd(input logic [7:0] a, e, input logic eh);
		rd_s = 1; addr = a; #1;
		`CHK("hit", eh, hit)
		cyc(); rd_s = 0;
		`CHK("rdata", e, rdata)
	endtask
	task automatic chk();
		for (int j = 0; j < 2; j++) begin
			`CHK("off", m_off[j][0], off[j])
			`CHK("thr", m_thr[j][2:0], thr[j])
		end
		`CHK("irq", (m_evt != 0), irq)
	endtask
	task automatic results();
		if (miscompares == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	// Cuts a hang short well past the expected few hundred cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			miscompares++;
			results();
		end
	end
	// ----------------------------------------
	// Stimulus
	// ----------------------------------------
	initial begin
		seed = 32'hF394; rst = 1; wr_s = 0; rd_s = 0; addr = 8'h00; wdata = 8'h00; sub = SUBMAP_USER;
		en = 1;
		vin = '{9000, 9000}; m_off = '{1, 1}; m_thr = '{3, 3}; m_evt = 0;
		repeat (2) @(posedge clk);
		#1 rst = 0;
		repeat (6) cyc(); // Overvoltage while powered down must not fire
		chk();
		sub = 2'h1; // Foreign sub map write is ignored
		wr(STB_SENSE_A_CTRL_OFS, 8'h00);
		sub = SUBMAP_USER;
		rd(8'h60, 8'h00, 1'b0);
		chk();
		vin = '{0, 0};
		repeat (3) cyc(); // Drain the synchroniser before any slicer is powered up
		// Every code on both inputs: exactly at level stays quiet, just above fires
		for (i = 0; i < 16; i++) begin
			k = i % 2; m_off[k] = 0; m_thr[k] = i / 2;
			wr(STB_SENSE_A_CTRL_OFS + 8'(k), 8'(m_thr[k] * 4));
			rd(STB_SENSE_A_CTRL_OFS + 8'(k), 8'(m_thr[k] * 4), 1'b1);
			lim = RATIO * (THRESH_BASE_MV + THRESH_STEP_MV * m_thr[k]);
			vin[k] = lim;
			repeat (6) cyc();
			chk();
			vin[k] = lim + RATIO + RATIO * ({$random(seed)} % 40);
			repeat (6) cyc();
			m_evt = 1 << k;
			chk();
			vin[k] = 0;
			repeat (3) cyc(); // Event must outlive the excursion
			rd(STB_STATUS_OFS, 8'(m_evt), 1'b1);
			m_evt = 0;
			cyc();
			chk();
		end
		en = 0; // Frozen core ignores a write
		wr(STB_SENSE_A_CTRL_OFS, 8'h40);
		en = 1;
		chk();
		vin = '{9000, 9000}; // Both fire; a read while still high is set again
		repeat (6) cyc();
		m_evt = 3;
		rd(STB_STATUS_OFS, 8'h03, 1'b1);
		chk();
		vin = '{0, 0};
		repeat (3) cyc();
		rd(STB_STATUS_OFS, 8'h03, 1'b1);
		m_evt = 0;
		cyc();
		chk();
		results();
	end
endmodule
`default_nettype wire
